// >>> pkg/pxr_pkg.sv
// Package for the extension-capability register bank of one switch port.
// Assumes an APB slave with 32-bit data and byte addresses equal to offsets.
package pxr_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] ERROR_HEADER_LOG_WORD3_OFF      = 12'h124;
  localparam logic [11:0] ERROR_HEADER_LOG_WORD4_OFF      = 12'h128;
  localparam logic [11:0] SERIAL_NUMBER_CAP_HEADER_OFF    = 12'h180;
  localparam logic [11:0] SERIAL_NUMBER_LOW_WORD_OFF      = 12'h184;
  localparam logic [11:0] SERIAL_NUMBER_HIGH_WORD_OFF     = 12'h188;
  localparam logic [11:0] VIRTUAL_CHANNEL_CAP_HEADER_OFF  = 12'h200;
  localparam logic [11:0] PORT_CHANNEL_CAPABILITY_ONE_OFF = 12'h204;
  localparam logic [11:0] LOG_STATUS_OFF                  = 12'h300;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  localparam int          CAP_ID_LSB          = 0;
  localparam int          CAP_VER_LSB         = 16;
  localparam int          NEXT_PTR_LSB        = 20;
  localparam logic [15:0] SERIAL_CAP_ID       = 16'h0003;
  localparam logic [15:0] CHANNEL_CAP_ID      = 16'h0002;
  localparam logic [3:0]  CAP_VERSION         = 4'h1;
  localparam logic [11:0] NEXT_PTR_RESET      = 12'h000;
  localparam int          EXTRA_CNT_LSB       = 0;
  localparam int          LP_EXTRA_CNT_LSB    = 4;
  localparam int          ARB_REF_CLK_LSB     = 8;
  localparam int          ENTRY_SIZE_LSB      = 10;
  localparam logic [2:0]  EXTRA_CNT_VAL       = 3'h0;
  localparam logic [2:0]  LP_EXTRA_CNT_VAL    = 3'h0;
  localparam logic [1:0]  ARB_REF_CLK_VAL     = 2'h0;
  localparam logic [1:0]  ENTRY_SIZE_UPSTREAM = 2'h2;
  localparam logic [1:0]  ENTRY_SIZE_DOWN     = 2'h0;
  localparam int          FIRST_ERR_LSB       = 0;
  localparam int          LOG_VALID_BIT       = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] HEADER_LOG_RESET    = 32'h0000_0000;
  localparam logic [31:0] SERIAL_HIGH_RESET   = 32'h0000_0000;
  localparam logic [4:0]  FIRST_ERR_RESET     = 5'h00;
  localparam logic [31:0] READ_ZERO           = 32'h0000_0000;

endpackage : pxr_pkg

// >>> core/pxr_sticky_log.sv
// Sticky first-error log: header words three and four plus error pointer.
// Assumes a cold power-on reset separate from the ordinary port reset.
`timescale 1ns/1ps
`default_nettype none

module pxr_sticky_log (
  input  wire logic        clk_in,
  input  wire logic        cold_rst_n_in,
  input  wire logic        err_valid_in,
  input  wire logic [4:0]  err_bit_in,
  input  wire logic [31:0] hdr_word3_in,
  input  wire logic [31:0] hdr_word4_in,
  input  wire logic        log_release_in,
  output logic [31:0]      header_log_word3_out,
  output logic [31:0]      header_log_word4_out,
  output logic [4:0]       first_error_pointer_out,
  output logic             log_held_out
);

  typedef struct packed {
    logic [31:0] word3;
    logic [31:0] word4;
    logic [4:0]  first_err;
    logic        held;
  } pxr_log_s;

  pxr_log_s st_r;
  pxr_log_s st_nxt;

  // Capture only the first error; later ones leave the log alone until a release
  always_comb begin
    st_nxt = st_r;
    if (st_r.held && log_release_in) begin
      st_nxt.held = 1'b0;
    end
    if (err_valid_in && (!st_r.held || log_release_in)) begin
      st_nxt.word3     = hdr_word3_in;
      st_nxt.word4     = hdr_word4_in;
      st_nxt.first_err = err_bit_in;
      st_nxt.held      = 1'b1;
    end
  end

  // Only the cold reset clears the log
  always_ff @(posedge clk_in or negedge cold_rst_n_in) begin
    if (!cold_rst_n_in) begin
      st_r.word3     <= pxr_pkg::HEADER_LOG_RESET;
      st_r.word4     <= pxr_pkg::HEADER_LOG_RESET;
      st_r.first_err <= pxr_pkg::FIRST_ERR_RESET;
      st_r.held      <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign header_log_word3_out    = st_r.word3;
  assign header_log_word4_out    = st_r.word4;
  assign first_error_pointer_out = st_r.first_err;
  assign log_held_out            = st_r.held;

  property p_first_only;
    @(posedge clk_in) disable iff (!cold_rst_n_in)
      (st_r.held && !log_release_in) |=> $stable(st_r.word3) && $stable(st_r.first_err);
  endproperty
  a_first_only: assert property (p_first_only) else $error("log changed while held");

  property p_capture;
    @(posedge clk_in) disable iff (!cold_rst_n_in)
      (err_valid_in && !st_r.held) |=> (st_r.word4 == $past(hdr_word4_in)) && st_r.held;
  endproperty
  a_capture: assert property (p_capture) else $error("fourth header word not captured");

  property p_pointer;
    @(posedge clk_in) disable iff (!cold_rst_n_in)
      (err_valid_in && !st_r.held) |=> (st_r.first_err == $past(err_bit_in));
  endproperty
  a_pointer: assert property (p_pointer) else $error("first error pointer not captured");

endmodule : pxr_sticky_log

`default_nettype wire

// >>> core/pxr_regs.sv
// Extension-capability register bank of one switch port, APB slave.
// Assumes APB master in the clk_in domain; cold reset clears sticky state.
`timescale 1ns/1ps
`default_nettype none

module pxr_regs (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cold_rst_n_in,
  input  wire logic        upstream_port_in,
  input  wire logic [31:0] unique_id_low_in,
  input  wire logic [31:0] unique_id_high_in,
  input  wire logic        id_lock_in,
  input  wire logic        err_valid_in,
  input  wire logic [4:0]  err_bit_in,
  input  wire logic [31:0] hdr_word3_in,
  input  wire logic [31:0] hdr_word4_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] serial_low;
    logic [11:0] serial_next_ptr;
    logic [11:0] channel_next_ptr;
    logic [31:0] prdata;
    logic        pslverr;
    logic        release_log;
    logic        low_loaded;
  } pxr_bank_s;

  typedef struct packed {
    logic [31:0] serial_high;
    logic        loaded;
  } pxr_sticky_s;

  pxr_bank_s   st_r;
  pxr_bank_s   st_nxt;
  pxr_sticky_s sk_r;
  pxr_sticky_s sk_nxt;

  logic [31:0] log_word3;
  logic [31:0] log_word4;
  logic [4:0]  first_err;
  logic        log_held;
  logic        access;
  logic        wr_en;
  logic        rd_hit;
  logic [31:0] rd_data;
  logic [31:0] sn_hdr_wr;
  logic [31:0] vc_hdr_wr;

  // Byte-lane merge for writable words
  function automatic logic [31:0] pxr_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : pxr_merge

  // Build a capability header word
  function automatic logic [31:0] pxr_cap_hdr(input logic [15:0] id,
                                             input logic [11:0] nptr);
    logic [31:0] res;
    res = pxr_pkg::READ_ZERO;
    res[pxr_pkg::CAP_ID_LSB +: 16]  = id;
    res[pxr_pkg::CAP_VER_LSB +: 4]  = pxr_pkg::CAP_VERSION;
    res[pxr_pkg::NEXT_PTR_LSB +: 12] = nptr;
    return res;
  endfunction : pxr_cap_hdr

  // ----------------------------------------------------------------------
  // Sticky header log
  // ----------------------------------------------------------------------
  pxr_sticky_log u_log (
    .clk_in                  (clk_in),
    .cold_rst_n_in           (cold_rst_n_in),
    .err_valid_in            (err_valid_in),
    .err_bit_in              (err_bit_in),
    .hdr_word3_in            (hdr_word3_in),
    .hdr_word4_in            (hdr_word4_in),
    .log_release_in          (st_r.release_log),
    .header_log_word3_out    (log_word3),
    .header_log_word4_out    (log_word4),
    .first_error_pointer_out (first_err),
    .log_held_out            (log_held)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Zero-wait slave: access phase completes at once
  assign access     = psel_in && penable_in;
  assign wr_en      = access && pwrite_in && !id_lock_in;
  assign pready_out = 1'b1;

  // Header words as a write would leave them; only the pointer field is kept
  assign sn_hdr_wr = pxr_merge(pxr_cap_hdr(pxr_pkg::SERIAL_CAP_ID, st_r.serial_next_ptr),
                               pwdata_in, pstrb_in);
  assign vc_hdr_wr = pxr_merge(pxr_cap_hdr(pxr_pkg::CHANNEL_CAP_ID, st_r.channel_next_ptr),
                               pwdata_in, pstrb_in);

  // Read mux; reserved bits stay zero
  always_comb begin
    rd_data = pxr_pkg::READ_ZERO;
    rd_hit  = 1'b1;
    unique case (paddr_in)
      pxr_pkg::ERROR_HEADER_LOG_WORD3_OFF:      rd_data = log_word3;
      pxr_pkg::ERROR_HEADER_LOG_WORD4_OFF:      rd_data = log_word4;
      pxr_pkg::SERIAL_NUMBER_CAP_HEADER_OFF:
        rd_data = pxr_cap_hdr(pxr_pkg::SERIAL_CAP_ID, st_r.serial_next_ptr);
      pxr_pkg::SERIAL_NUMBER_LOW_WORD_OFF:      rd_data = st_r.serial_low;
      pxr_pkg::SERIAL_NUMBER_HIGH_WORD_OFF:     rd_data = sk_r.serial_high;
      pxr_pkg::VIRTUAL_CHANNEL_CAP_HEADER_OFF:
        rd_data = pxr_cap_hdr(pxr_pkg::CHANNEL_CAP_ID, st_r.channel_next_ptr);
      pxr_pkg::PORT_CHANNEL_CAPABILITY_ONE_OFF: begin
        rd_data[pxr_pkg::EXTRA_CNT_LSB +: 3]    = pxr_pkg::EXTRA_CNT_VAL;
        rd_data[pxr_pkg::LP_EXTRA_CNT_LSB +: 3] = pxr_pkg::LP_EXTRA_CNT_VAL;
        rd_data[pxr_pkg::ARB_REF_CLK_LSB +: 2]  = pxr_pkg::ARB_REF_CLK_VAL;
        rd_data[pxr_pkg::ENTRY_SIZE_LSB +: 2]   = upstream_port_in ?
                                                  pxr_pkg::ENTRY_SIZE_UPSTREAM :
                                                  pxr_pkg::ENTRY_SIZE_DOWN;
      end
      pxr_pkg::LOG_STATUS_OFF: begin
        rd_data[pxr_pkg::FIRST_ERR_LSB +: 5] = first_err;
        rd_data[pxr_pkg::LOG_VALID_BIT]      = log_held;
      end
      default:                                  rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt             = st_r;
    sk_nxt             = sk_r;
    st_nxt.release_log = 1'b0;
    st_nxt.prdata      = pxr_pkg::READ_ZERO;
    st_nxt.pslverr     = 1'b0;
    // Low word reloads after an ordinary reset, high word after a cold one only
    if (!st_r.low_loaded) begin
      st_nxt.serial_low = unique_id_low_in;
      st_nxt.low_loaded = 1'b1;
    end
    if (!sk_r.loaded) begin
      sk_nxt.serial_high = unique_id_high_in;
      sk_nxt.loaded      = 1'b1;
    end
    // Answer decoded in the setup phase, shown from a flop in the access phase
    if (psel_in && !penable_in) begin
      st_nxt.prdata  = pwrite_in ? pxr_pkg::READ_ZERO : rd_data;
      st_nxt.pslverr = !rd_hit;
    end
    // Writes reach only the lockable fields; all else ignores them
    if (wr_en && rd_hit) begin
      unique case (paddr_in)
        pxr_pkg::SERIAL_NUMBER_CAP_HEADER_OFF: begin
          st_nxt.serial_next_ptr = sn_hdr_wr[pxr_pkg::NEXT_PTR_LSB +: 12];
        end
        pxr_pkg::VIRTUAL_CHANNEL_CAP_HEADER_OFF: begin
          st_nxt.channel_next_ptr = vc_hdr_wr[pxr_pkg::NEXT_PTR_LSB +: 12];
        end
        pxr_pkg::SERIAL_NUMBER_LOW_WORD_OFF:  st_nxt.serial_low  = pxr_merge(st_r.serial_low, pwdata_in, pstrb_in);
        pxr_pkg::SERIAL_NUMBER_HIGH_WORD_OFF: sk_nxt.serial_high = pxr_merge(sk_r.serial_high, pwdata_in, pstrb_in);
        pxr_pkg::LOG_STATUS_OFF:              st_nxt.release_log = pwdata_in[pxr_pkg::LOG_VALID_BIT];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Ordinary reset: non-sticky fields to defaults
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r.serial_low       <= pxr_pkg::READ_ZERO;
      st_r.serial_next_ptr  <= pxr_pkg::NEXT_PTR_RESET;
      st_r.channel_next_ptr <= pxr_pkg::NEXT_PTR_RESET;
      st_r.prdata           <= pxr_pkg::READ_ZERO;
      st_r.pslverr          <= 1'b0;
      st_r.release_log      <= 1'b0;
      st_r.low_loaded       <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Cold reset only: sticky serial high word
  always_ff @(posedge clk_in or negedge cold_rst_n_in) begin
    if (!cold_rst_n_in) begin
      sk_r.serial_high <= pxr_pkg::SERIAL_HIGH_RESET;
      sk_r.loaded      <= 1'b0;
    end else begin
      sk_r <= sk_nxt;
    end
  end

  // Registered answer; zero outside the access phase that follows a setup
  assign prdata_out  = st_r.prdata;
  assign pslverr_out = st_r.pslverr;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_read(logic [11:0] a);
    psel_in && penable_in && !pwrite_in && paddr_in == a;
  endsequence

  property p_serial_hdr;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_read(pxr_pkg::SERIAL_NUMBER_CAP_HEADER_OFF) |-> prdata_out[19:0] == 20'h10003;
  endproperty
  a_serial_hdr: assert property (p_serial_hdr) else $error("serial header id or version wrong");

  property p_channel_hdr;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_read(pxr_pkg::VIRTUAL_CHANNEL_CAP_HEADER_OFF) |-> prdata_out[19:0] == 20'h10002;
  endproperty
  a_channel_hdr: assert property (p_channel_hdr) else $error("channel header id or version wrong");

  property p_version;
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_read(pxr_pkg::SERIAL_NUMBER_CAP_HEADER_OFF) or s_read(pxr_pkg::VIRTUAL_CHANNEL_CAP_HEADER_OFF))
        |-> prdata_out[19:16] == 4'h1;
  endproperty
  a_version: assert property (p_version) else $error("capability version wrong");

  property p_next_ptr_reset;
    @(posedge clk_in) $rose(rst_n_in) |-> st_r.channel_next_ptr == 12'h000;
  endproperty
  a_next_ptr_reset: assert property (p_next_ptr_reset) else $error("next pointer not zero at reset");

  property p_cap_one;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_read(pxr_pkg::PORT_CHANNEL_CAPABILITY_ONE_OFF)
        |-> prdata_out[9:0] == 10'h000 && prdata_out[31:12] == 20'h00000;
  endproperty
  a_cap_one: assert property (p_cap_one) else $error("channel counts or reserved bits nonzero");

  property p_entry_size;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_read(pxr_pkg::PORT_CHANNEL_CAPABILITY_ONE_OFF)
        |-> prdata_out[11:10] == (upstream_port_in ? 2'h2 : 2'h0);
  endproperty
  a_entry_size: assert property (p_entry_size) else $error("entry size wrong for port type");

  property p_ro_write;
    @(posedge clk_in) disable iff (!rst_n_in)
      (access && pwrite_in && paddr_in == pxr_pkg::ERROR_HEADER_LOG_WORD3_OFF && !err_valid_in && log_held)
        |=> $stable(log_word3);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only log changed by write");

  property p_high_read;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_read(pxr_pkg::SERIAL_NUMBER_HIGH_WORD_OFF) |-> prdata_out == sk_r.serial_high;
  endproperty
  a_high_read: assert property (p_high_read) else $error("high serial word misread");

  property p_sticky_keep;
    @(posedge clk_in) disable iff (!cold_rst_n_in)
      (!rst_n_in && sk_r.loaded) |=> $stable(sk_r.serial_high);
  endproperty
  a_sticky_keep: assert property (p_sticky_keep) else $error("sticky word lost on warm reset");

endmodule : pxr_regs

`default_nettype wire

// >>> tb/pxr_tb.sv
// Self-checking testbench for the port extension-capability register bank.
// Assumes pxr_regs and pxr_pkg are compiled first; APB answers with no waits.
`timescale 1ns/1ps
`default_nettype none

module testbench;

  // --------------------------------------------------------------------
  // Signals and constants
  // --------------------------------------------------------------------
  typedef struct {
    logic [11:0] addr;
    logic [31:0] val;
  } pxr_row_s;

  localparam logic [31:0] ID_LO   = 32'h1357_9bdf;  // Arbitrary test identifier
  localparam logic [31:0] ID_HI   = 32'h2468_ace0;  // Arbitrary test identifier
  localparam logic [31:0] ID_HI2  = 32'h0bad_f00d;  // Loaded at the second cold reset
  localparam logic [31:0] SN_HDR  = {pxr_pkg::NEXT_PTR_RESET, pxr_pkg::CAP_VERSION, pxr_pkg::SERIAL_CAP_ID};
  localparam logic [31:0] VC_HDR  = {pxr_pkg::NEXT_PTR_RESET, pxr_pkg::CAP_VERSION, pxr_pkg::CHANNEL_CAP_ID};
  localparam logic [31:0] CAP1_UP = {20'h0, pxr_pkg::ENTRY_SIZE_UPSTREAM, 10'h000};

  logic        clk_in;
  logic        rst_n_in;
  logic        cold_rst_n_in;
  logic        upstream_port_in;
  logic [31:0] unique_id_low_in;
  logic [31:0] unique_id_high_in;
  logic        id_lock_in;
  logic        err_valid_in;
  logic [4:0]  err_bit_in;
  logic [31:0] hdr_word3_in;
  logic [31:0] hdr_word4_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [3:0]  pstrb_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  int          err_count;
  int          n_checks;
  logic [31:0] rd;
  logic        rerr;
  pxr_row_s    rows [8];

  pxr_regs DUT (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .cold_rst_n_in     (cold_rst_n_in),
    .upstream_port_in  (upstream_port_in),
    .unique_id_low_in  (unique_id_low_in),
    .unique_id_high_in (unique_id_high_in),
    .id_lock_in        (id_lock_in),
    .err_valid_in      (err_valid_in),
    .err_bit_in        (err_bit_in),
    .hdr_word3_in      (hdr_word3_in),
    .hdr_word4_in      (hdr_word4_in),
    .psel_in           (psel_in),
    .penable_in        (penable_in),
    .pwrite_in         (pwrite_in),
    .paddr_in          (paddr_in),
    .pwdata_in         (pwdata_in),
    .pstrb_in          (pstrb_in),
    .prdata_out        (prdata_out),
    .pready_out        (pready_out),
    .pslverr_out       (pslverr_out)
  );

  // --------------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // --------------------------------------------------------------------
  // 100 ns period clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Cuts a hang short; the tests need well under 300 cycles
  initial begin
    #(2000 * 100);
    err_count++;
    give_verdict();
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                          input logic [3:0] st, output logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= wr;
    paddr_in  <= a;
    pwdata_in <= wd;
    pstrb_in  <= st;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("FAIL pready expected 1 seen %b", pready_out);
    end
    d = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb_xfer

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0, 4'h0, rd, rerr);
    check(name, rd, exp);
    check("pslverr", {31'h0, rerr}, 32'h0);
  endtask : rd_chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
    apb_xfer(1'b1, a, d, st, rd, rerr);
  endtask : wr

  // One-cycle error report with its header words
  task automatic report_err(input logic [4:0] b, input logic [31:0] w3, input logic [31:0] w4);
    @(posedge clk_in);
    err_valid_in <= 1'b1;
    err_bit_in   <= b;
    hdr_word3_in <= w3;
    hdr_word4_in <= w4;
    @(posedge clk_in);
    err_valid_in <= 1'b0;
  endtask : report_err

  task automatic do_reset(input logic cold);
    @(posedge clk_in);
    rst_n_in      <= 1'b0;
    cold_rst_n_in <= ~cold;
    repeat (6) @(posedge clk_in);
    rst_n_in      <= 1'b1;
    cold_rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask : do_reset

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    err_count = 0;
    n_checks = 0;
    rst_n_in = 1'b0;
    cold_rst_n_in = 1'b0;
    upstream_port_in = 1'b1;
    unique_id_low_in = ID_LO;
    unique_id_high_in = ID_HI;
    id_lock_in = 1'b0;
    err_valid_in = 1'b0;
    err_bit_in = 5'h00;
    hdr_word3_in = 32'h0;
    hdr_word4_in = 32'h0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    pstrb_in = 4'h0;
    rows = '{'{12'h124, 32'h0}, '{12'h128, 32'h0}, '{12'h180, SN_HDR}, '{12'h184, ID_LO},
             '{12'h188, ID_HI}, '{12'h200, VC_HDR}, '{12'h204, CAP1_UP}, '{12'h300, 32'h0}};
    repeat (6) @(posedge clk_in);
    rst_n_in      <= 1'b1;
    cold_rst_n_in <= 1'b1;
    @(posedge clk_in);

    // Reset values of every register, upstream port
    foreach (rows[i]) begin
      rd_chk("reset value", rows[i].addr, rows[i].val);
    end
    $display("test reset_values done");

    // Downstream port reports the small entry size
    upstream_port_in <= 1'b0;
    rd_chk("cap1 downstream", 12'h204, 32'h0);
    upstream_port_in <= 1'b1;
    $display("test entry_size done");

    // Writes to read-only words and fields leave them alone
    wr(12'h124, 32'hffff_ffff, 4'hf);
    wr(12'h204, 32'hffff_ffff, 4'hf);
    wr(12'h180, 32'hffff_ffff, 4'hf);
    wr(12'h200, 32'h0abc_def0, 4'hf);
    rd_chk("log word3 ro", 12'h124, 32'h0);
    rd_chk("cap1 ro", 12'h204, CAP1_UP);
    rd_chk("serial hdr ptr", 12'h180, 32'hfff1_0003);
    rd_chk("vc hdr ptr", 12'h200, 32'h0ab1_0002);
    $display("test read_only done");

    // Lock blocks writes; byte strobes select lanes
    id_lock_in <= 1'b1;
    wr(12'h188, 32'h1111_1111, 4'hf);
    rd_chk("high word locked", 12'h188, ID_HI);
    id_lock_in <= 1'b0;
    wr(12'h188, 32'h1234_5678, 4'h3);
    rd_chk("high word strobed", 12'h188, {ID_HI[31:16], 16'h5678});
    $display("test lock_strobe done");

    // Unmapped address answers with an error
    wr(12'h3fc, 32'hffff_ffff, 4'hf);
    check("pslverr write", {31'h0, rerr}, 32'h1);
    apb_xfer(1'b0, 12'h3fc, 32'h0, 4'h0, rd, rerr);
    check("pslverr read", {31'h0, rerr}, 32'h1);
    $display("test unmapped done");

    // First error is logged, a second is ignored until released
    report_err(5'h0c, 32'hcafe_0003, 32'hbeef_0004);
    report_err(5'h15, 32'h5555_5555, 32'haaaa_aaaa);
    wr(12'h124, 32'hffff_ffff, 4'hf);
    rd_chk("log word3", 12'h124, 32'hcafe_0003);
    rd_chk("log word4", 12'h128, 32'hbeef_0004);
    rd_chk("log status", 12'h300, 32'h0000_010c);
    wr(12'h300, 32'h0000_0100, 4'hf);
    rd_chk("log released", 12'h300, 32'h0000_000c);
    report_err(5'h15, 32'h5555_5555, 32'haaaa_aaaa);
    rd_chk("log word3 new", 12'h124, 32'h5555_5555);
    rd_chk("log word4 new", 12'h128, 32'haaaa_aaaa);
    rd_chk("log status new", 12'h300, 32'h0000_0115);
    $display("test error_log done");

    // Warm reset keeps sticky state, restores the rest
    unique_id_high_in <= ID_HI2;
    do_reset(1'b0);
    rd_chk("warm word3", 12'h124, 32'h5555_5555);
    rd_chk("warm status", 12'h300, 32'h0000_0115);
    rd_chk("warm high", 12'h188, {ID_HI[31:16], 16'h5678});
    rd_chk("warm low", 12'h184, ID_LO);
    rd_chk("warm serial hdr", 12'h180, SN_HDR);
    rd_chk("warm vc hdr", 12'h200, VC_HDR);
    $display("test warm_reset done");

    // Cold reset clears sticky state and reloads the identifier
    do_reset(1'b1);
    rd_chk("cold word4", 12'h128, 32'h0);
    rd_chk("cold status", 12'h300, 32'h0);
    rd_chk("cold high", 12'h188, ID_HI2);
    rd_chk("cold low", 12'h184, ID_LO);
    $display("test cold_reset done");

    give_verdict();
  end

endmodule : testbench

`default_nettype wire
